// [rtl/pwc_periodic_wakeup_counter.sv]
// Periodic wakeup counter with APB register access
`timescale 1ns/1ps
module pwc_periodic_wakeup_counter
    import pwc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lowPowerOsc1khz,
    input wire logic externalReferenceClock,
    input wire logic internal32khzClock,
    input wire logic backgroundDebug,
    input wire logic deepHaltMode,
    output logic matchIrq,
    output logic wakeRequest
);
    typedef struct packed {
        logic [1:0] syncLpo;
        logic [1:0] syncExt;
        logic [1:0] syncInt;
        logic [1:0] syncDbg;
        logic [1:0] syncDeep;
        logic lastSrc;
        logic matchFlag;
        logic [1:0] sourceSelect;
        logic matchIe;
        logic [3:0] dividerSelect;
        logic [7:0] count;
        logic [7:0] limit;
        logic [17:0] pre;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic irq;
        logic wake;
    } pwc_state_s;

    pwc_state_s st;
    pwc_state_s next_st;

    // Divide ratio for the current source bit 0 and divider code
    // A ratio of zero means the prescaler is off
    function automatic logic [17:0] divideBy(input logic srcBit0,
                                             input logic [3:0] sel);
        logic [17:0] binaryRatio;
        logic [17:0] decadeRatio;
        binaryRatio = DIV_TAB0[sel];
        decadeRatio = DIV_TAB1[sel];
        case (srcBit0)
            1'b0: divideBy = binaryRatio;
            1'b1: divideBy = decadeRatio;
            default: divideBy = PRE_RESET;
        endcase
    endfunction

    function automatic logic regHit(input logic [11:0] a,
                                    input logic [11:0] off);
        regHit = (a == off);
    endfunction

    // Read decode: bit 8 flags an unmapped address, which reads zero
    function automatic logic [8:0] readDecode(input logic [11:0] a,
                                              input logic [7:0] status,
                                              input logic [7:0] cnt,
                                              input logic [7:0] lim);
        logic [8:0] r;
        r = 9'h000;
        if (regHit(a, OFF_STATUS_CONTROL)) begin
            r[7:0] = status;
        end else if (regHit(a, OFF_COUNT_VALUE)) begin
            r[7:0] = cnt;
        end else if (regHit(a, OFF_MATCH_LIMIT)) begin
            r[7:0] = lim;
        end else begin
            r[8] = 1'b1;
        end
        readDecode = r;
    endfunction

    // Synchronised level of the source picked by the select code
    function automatic logic sourceLevel(input logic [1:0] sel,
                                         input logic low_power_osc_1khz,
                                         input logic ext,
                                         input logic int32k);
        case (sel)
            SRC_LPO: sourceLevel = low_power_osc_1khz;
            SRC_EXT: sourceLevel = ext;
            default: sourceLevel = int32k;
        endcase
    endfunction

    // Only the low-power osc keeps running in deep halt
    function automatic logic sourceAlive(input logic [1:0] sel,
                                         input logic deep);
        sourceAlive = !deep || (sel == SRC_LPO);
    endfunction

    // Status/control image as software reads it
    // Built from the field positions so the map lives in one place
    function automatic logic [7:0] statusWord(input logic flag,
                                              input logic [1:0] src,
                                              input logic ie,
                                              input logic [3:0] div);
        logic [7:0] w;
        w = 8'h00;
        w[FLAG_BIT] = flag;
        w[SRC_HI:SRC_LO] = src;
        w[IE_BIT] = ie;
        w[DIV_HI:0] = div;
        statusWord = w;
    endfunction

    // True when a status write alters the source or divider code
    function automatic logic settingsChanged(input logic [7:0] w,
                                             input logic [1:0] src,
                                             input logic [3:0] div);
        logic srcDiffers;
        logic divDiffers;
        srcDiffers = (w[SRC_HI:SRC_LO] != src);
        divDiffers = (w[DIV_HI:0] != div);
        settingsChanged = srcDiffers || divDiffers;
    endfunction

    // Prescaler step on a source edge: wraps after divisor edges and
    // reports the wrap in bit 18 as a tick for the main counter
    function automatic logic [18:0] prescaleStep(input logic [17:0] pre,
                                                 input logic [17:0] div);
        logic wrap;
        logic [17:0] nextPre;
        wrap = (pre >= div - 18'd1);
        if (wrap) begin
            nextPre = PRE_RESET;
        end else begin
            nextPre = pre + 18'd1;
        end
        prescaleStep = {wrap, nextPre};
    endfunction

    // Next counter value on a prescaler tick: wrap to zero on a match
    // The limit itself is a valid count; zero flags every tick
    function automatic logic [7:0] countStep(input logic [7:0] cnt,
                                             input logic [7:0] lim);
        if (cnt == lim) begin
            countStep = COUNT_RESET;
        end else begin
            countStep = cnt + 8'h01;
        end
    endfunction

    // Hardware set wins over a write-1 clear in the same cycle, so a
    // match that lands on the clearing write is kept unless that write also restarts the counters
    function automatic logic flagNext(input logic flag,
                                      input logic setEvent,
                                      input logic clearEvent);
        if (setEvent) begin
            flagNext = 1'b1;
        end else if (clearEvent) begin
            flagNext = 1'b0;
        end else begin
            flagNext = flag;
        end
    endfunction

    // Combinational helpers, all given a value on every pass
    logic srcLevel;
    logic srcRise;
    logic srcAlive;
    logic tick;
    logic clearCounters;
    logic accessDone;
    logic [17:0] divisor;
    logic [7:0] wsc;
    logic [7:0] statusNow;
    logic [7:0] readByte;
    logic readMiss;
    logic statusWrite;
    logic limitWrite;
    logic matchNow;
    logic preWrap;
    logic [17:0] preNext;
    logic counting;

    always_comb begin
        next_st = st;
        // Second flop of each synchroniser feeds all logic
        next_st.syncLpo = {st.syncLpo[0], lowPowerOsc1khz};
        next_st.syncExt = {st.syncExt[0], externalReferenceClock};
        next_st.syncInt = {st.syncInt[0], internal32khzClock};
        next_st.syncDbg = {st.syncDbg[0], backgroundDebug};
        next_st.syncDeep = {st.syncDeep[0], deepHaltMode};

        // Source edges are found on the bus clock, so each source must
        // stay below a quarter of the bus clock rate
        srcLevel = sourceLevel(st.sourceSelect, st.syncLpo[1],
                               st.syncExt[1], st.syncInt[1]);
        srcAlive = sourceAlive(st.sourceSelect, st.syncDeep[1]);
        next_st.lastSrc = srcLevel;
        srcRise = srcLevel && !st.lastSrc && srcAlive;

        divisor = divideBy(st.sourceSelect[0], st.dividerSelect);
        // Hold the prescaler and counter while debug is active
        counting = (divisor != PRE_RESET) && !st.syncDbg[1];
        {preWrap, preNext} = prescaleStep(st.pre, divisor);
        tick = 1'b0;
        clearCounters = 1'b0;
        if (counting && srcRise) begin
            next_st.pre = preNext;
            tick = preWrap;
        end
        matchNow = tick && (st.count == st.limit);
        if (tick) begin
            next_st.count = countStep(st.count, st.limit);
        end

        // One wait state: the access is taken on the first access-phase
        // edge and answered by a registered ready on the next one
        accessDone = psel && penable && !st.ready;
        statusWrite = accessDone && pwrite &&
                      regHit(paddr, OFF_STATUS_CONTROL);
        limitWrite = accessDone && pwrite && regHit(paddr, OFF_MATCH_LIMIT);
        wsc = pwdata[7:0];
        statusNow = statusWord(st.matchFlag, st.sourceSelect, st.matchIe,
                               st.dividerSelect);
        {readMiss, readByte} = readDecode(paddr, statusNow, st.count,
                                          st.limit);
        next_st.ready = accessDone;
        next_st.err = accessDone && readMiss;
        if (accessDone) begin
            next_st.rdata = {24'h000000, readByte};
        end

        // Writes to the count register are dropped
        if (statusWrite) begin
            if (settingsChanged(wsc, st.sourceSelect, st.dividerSelect)) begin
                clearCounters = 1'b1;
            end
            next_st.sourceSelect = wsc[SRC_HI:SRC_LO];
            next_st.matchIe = wsc[IE_BIT];
            next_st.dividerSelect = wsc[DIV_HI:0];
        end
        if (limitWrite) begin
            next_st.limit = wsc;
            clearCounters = 1'b1;
        end

        if (clearCounters) begin
            next_st.pre = PRE_RESET;
            next_st.count = COUNT_RESET;
        end
        // A restart of the counters drops the match of that cycle
        next_st.matchFlag = flagNext(st.matchFlag,
                                     matchNow && !clearCounters,
                                     statusWrite && wsc[FLAG_BIT]);

        next_st.irq = next_st.matchFlag && next_st.matchIe;
        next_st.wake = next_st.irq;

        if (srst) begin
            next_st = '0;
            next_st.sourceSelect = SRC_RESET;
            next_st.dividerSelect = DIV_RESET;
            next_st.count = COUNT_RESET;
            next_st.limit = LIMIT_RESET;
            next_st.pre = PRE_RESET;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign prdata = st.rdata;
    assign pready = st.ready;
    assign pslverr = st.err;
    assign matchIrq = st.irq;
    assign wakeRequest = st.wake;
endmodule // pwc_periodic_wakeup_counter

// [rtl/pwc_pkg.sv]
// Package with register map, field positions and reset values
package pwc_pkg;
    // Register byte addresses (word aligned)
    localparam logic [11:0] OFF_STATUS_CONTROL = 12'h000;
    localparam logic [11:0] OFF_COUNT_VALUE = 12'h004;
    localparam logic [11:0] OFF_MATCH_LIMIT = 12'h008;
    // Status/control field positions
    localparam int FLAG_BIT = 7;
    localparam int SRC_HI = 6;
    localparam int SRC_LO = 5;
    localparam int IE_BIT = 4;
    localparam int DIV_HI = 3;
    // Reset values
    localparam logic [1:0] SRC_RESET = 2'h0;
    localparam logic [3:0] DIV_RESET = 4'h0;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] LIMIT_RESET = 8'h00;
    localparam logic [17:0] PRE_RESET = 18'h00000;
    // Source select codes
    localparam logic [1:0] SRC_LPO = 2'h0;
    localparam logic [1:0] SRC_EXT = 2'h1;
    // Prescaler divide-by tables, index is divider_select, 0 means off
    localparam logic [17:0] DIV_TAB0 [16] = '{
        18'd0, 18'd8, 18'd32, 18'd64, 18'd128, 18'd256, 18'd512,
        18'd1024, 18'd1, 18'd2, 18'd4, 18'd10, 18'd16, 18'd100,
        18'd500, 18'd1000};
    localparam logic [17:0] DIV_TAB1 [16] = '{
        18'd0, 18'd1024, 18'd2048, 18'd4096, 18'd8192, 18'd16384,
        18'd32768, 18'd65536, 18'd1000, 18'd2000, 18'd5000,
        18'd10000, 18'd20000, 18'd50000, 18'd100000, 18'd200000};
endpackage

// [verif/pwc_asserts.sv]
// Port-level assertions for the periodic wakeup counter
`timescale 1ns/1ps
module pwc_asserts
    import pwc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic backgroundDebug,
    input wire logic matchIrq,
    input wire logic wakeRequest
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // High on the cycle after a status/control write took effect
    wire logic scWr = pready && pwrite && paddr == OFF_STATUS_CONTROL;
    wire logic mapped = paddr == OFF_STATUS_CONTROL ||
        paddr == OFF_COUNT_VALUE || paddr == OFF_MATCH_LIMIT;
    wake_follow_a: assert property (matchIrq == wakeRequest)
        else $error("wake request differs from match request");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    ready_cause_a: assert property
        (pready |-> psel && penable && $past(psel && penable))
        else $error("ready without an access phase");
    err_map_a: assert property (pready |-> pslverr == !mapped)
        else $error("error response does not match address map");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error response outside ready");
    rd_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == '0)
        else $error("upper read data not zero");
    ie_off_a: assert property (scWr && !pwdata[IE_BIT] |-> !matchIrq)
        else $error("request with interrupt enable cleared");
    irq_fall_a: assert property ($fell(matchIrq) |-> scWr)
        else $error("request dropped without a status write");
    debug_hold_a: assert property
        (backgroundDebug [*6] |=> !$rose(matchIrq) || scWr)
        else $error("match raised while counting is held");
    cover property ($rose(matchIrq));
    cover property (pslverr);
    cover property (scWr && pwdata[FLAG_BIT]);
endmodule // pwc_asserts
bind pwc_periodic_wakeup_counter pwc_asserts i_chk (.*);

// [verif/tb_top.sv]
// Self-checking bench for the periodic wakeup counter
`timescale 1ns/1ps
module tb_top
    import pwc_pkg::*;
;
    logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, er;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r, held;
    logic pready, pslverr, matchIrq, wakeRequest, backgroundDebug = 0;
    logic lowPowerOsc1khz = 0, externalReferenceClock = 0;
    logic internal32khzClock = 0, deepHaltMode = 0;
    int n_fail = 0, n_compared = 0, cyc = 0;
    pwc_periodic_wakeup_counter i_dut (.*);
    initial forever #25 clk = ~clk;
    // Source clocks kept slower than a quarter of the bus clock
    initial forever #200 lowPowerOsc1khz = ~lowPowerOsc1khz;
    initial forever #350 externalReferenceClock = ~externalReferenceClock;
    initial forever #150 internal32khzClock = ~internal32khzClock;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value at %0t: %h, expected %h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a,
            input logic [7:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n == 40) begin
            n_fail++;
            report_and_stop();
        end
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h00);
        chk(r, e);
    endtask
    task automatic t_reset;
        rd(OFF_STATUS_CONTROL, '0);
        rd(OFF_MATCH_LIMIT, '0);
        bus(1'b1, 12'h00c, 8'h5a);
        chk(32'(er), 32'h1);
        bus(1'b1, OFF_COUNT_VALUE, 8'h5a);
        rd(OFF_COUNT_VALUE, '0);
        $display("t_reset done");
    endtask
    task automatic t_match;
        int n = 0;
        bus(1'b1, OFF_MATCH_LIMIT, 8'hff);
        bus(1'b1, OFF_STATUS_CONTROL, 8'h18);
        repeat (40) @(posedge clk);
        // Freeze counting so the limit-write clear is not raced by a tick
        backgroundDebug <= 1'b1;
        repeat (4) @(posedge clk);
        bus(1'b1, OFF_MATCH_LIMIT, 8'h03);
        rd(OFF_COUNT_VALUE, '0);
        backgroundDebug <= 1'b0;
        while (matchIrq !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        rd(OFF_STATUS_CONTROL, 32'h98);
        bus(1'b1, OFF_STATUS_CONTROL, 8'h18);
        rd(OFF_STATUS_CONTROL, 32'h98);
        bus(1'b1, OFF_STATUS_CONTROL, 8'h98);
        chk(32'(matchIrq), 32'h0);
        bus(1'b1, OFF_MATCH_LIMIT, 8'h00);
        repeat (24) @(posedge clk);
        rd(OFF_STATUS_CONTROL, 32'h98);
        $display("t_match done");
    endtask
    task automatic t_debug;
        bus(1'b1, OFF_MATCH_LIMIT, 8'hff);
        repeat (40) @(posedge clk);
        backgroundDebug <= 1'b1;
        repeat (10) @(posedge clk);
        bus(1'b0, OFF_COUNT_VALUE, 8'h00);
        held = r;
        repeat (60) @(posedge clk);
        rd(OFF_COUNT_VALUE, held);
        backgroundDebug <= 1'b0;
        $display("t_debug done");
    endtask
    task automatic t_change;
        repeat (40) @(posedge clk);
        bus(1'b1, OFF_STATUS_CONTROL, 8'h89);
        rd(OFF_COUNT_VALUE, '0);
        repeat (60) @(posedge clk);
        bus(1'b1, OFF_STATUS_CONTROL, 8'h49);
        rd(OFF_COUNT_VALUE, '0);
        rd(OFF_STATUS_CONTROL, 32'h49);
        deepHaltMode <= 1'b1;
        repeat (4) @(posedge clk);
        bus(1'b1, OFF_STATUS_CONTROL, 8'h48);
        repeat (80) @(posedge clk);
        rd(OFF_COUNT_VALUE, '0);
        deepHaltMode <= 1'b0;
        $display("t_change done");
    endtask
    task automatic report_and_stop;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_match();
        t_debug();
        t_change();
        report_and_stop();
    end
endmodule // tb_top
